// ### ebr_block_ram.sv
// Embedded block RAM: 9 Kbit array, two ports, preload and shape control.
// Assumes one clock for both ports and synchronous user logic on each port.
//
// Overview of operation
// - One 9 Kbit array with registers at its inputs and data outputs.
// - Works as single port, true dual port or pseudo dual port memory.
// - Each port picks its own width, its depth follows from it.
// - Word 0 sits in the lowest bits LSB first, then word 1, per port.
// - Contents can be preloaded before user operation starts.
// - Preloaded with writes held off, the block acts as a ROM.
// - Address and write data are registered before the array access.
// - Each read port may pass data through an output register or not.
// - Contents and registers hold in normal use, not in sleep.
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module ebr_block_ram (
    input  wire logic                            mclk_i,
    input  wire logic                            nrst_i,
    input  wire logic                            low_power_request_n_i,
    input  ebr_pkg::ebr_mode_type                mode_i,
    input  ebr_pkg::ebr_width_type               width_a_i,
    input  ebr_pkg::ebr_width_type               width_b_i,
    input  wire logic                            out_reg_a_i,
    input  wire logic                            out_reg_b_i,
    input  wire logic                            init_we_i,
    input  wire logic [ebr_pkg::INIT_ADDR_W-1:0] init_addr_i,
    input  wire logic [ebr_pkg::DATA_W-1:0]      init_data_i,
    input  wire logic                            a_en_i,
    input  wire logic                            a_we_i,
    input  wire logic [ebr_pkg::ADDR_W-1:0]      a_addr_i,
    input  wire logic [ebr_pkg::DATA_W-1:0]      a_wdata_i,
    input  wire logic                            b_en_i,
    input  wire logic                            b_we_i,
    input  wire logic [ebr_pkg::ADDR_W-1:0]      b_addr_i,
    input  wire logic [ebr_pkg::DATA_W-1:0]      b_wdata_i,
    output logic      [ebr_pkg::DATA_W-1:0]      a_rdata_o,
    output logic      [ebr_pkg::DATA_W-1:0]      b_rdata_o,
    output logic                                 shape_err_o
);
    import ebr_pkg::*;

    // Storage array, one flip-flop per bit
    logic [ARRAY_BITS-1:0] mem_q;

    // Effective shapes and port permissions
    ebr_width_type wa;
    ebr_width_type wb;
    logic          a_wr_ok;
    logic          a_rd_ok;
    logic          b_wr_ok;
    logic          b_rd_ok;
    logic          sleep;

    // Registered port requests
    logic              a_wr;
    logic              a_rd;
    logic [ADDR_W-1:0] a_addr;
    logic [DATA_W-1:0] a_wdata;
    logic              b_wr;
    logic              b_rd;
    logic [ADDR_W-1:0] b_addr;
    logic [DATA_W-1:0] b_wdata;

    // Array read words
    logic [DATA_W-1:0] a_arr;
    logic [DATA_W-1:0] b_arr;

    // First array bit of a word: word index times width
    function automatic logic [BIT_IDX_W-1:0] bit_base(
        input logic [ADDR_W-1:0] addr,
        input ebr_width_type     w
    );
        logic [BIT_IDX_W+5:0] prod;
        prod     = (BIT_IDX_W+6)'(addr) * (BIT_IDX_W+6)'(width_bits(w));
        bit_base = prod[BIT_IDX_W-1:0];
    endfunction

    // Gather one word from the array, LSB at the lowest bit
    function automatic logic [DATA_W-1:0] read_word(
        input logic [ARRAY_BITS-1:0] arr,
        input logic [ADDR_W-1:0]     addr,
        input ebr_width_type         w
    );
        logic [BIT_IDX_W-1:0] base;
        int                   n;
        base      = bit_base(addr, w);
        n         = width_bits(w);
        read_word = RST_DATA;
        for (int i = 0; i < DATA_W; i++) begin
            if (i < n && (int'(base) + i) < ARRAY_BITS) begin
                read_word[i] = arr[int'(base) + i];
            end
        end
    endfunction

    // Shapes follow the arrangement; x36 falls back to x18 in true dual
    always_comb begin
        wa = eff_width(mode_i, width_a_i);
        wb = eff_width(mode_i, width_b_i);
        sleep = ~low_power_request_n_i;
    end

    // Which port may read or write in each arrangement
    always_comb begin
        case (mode_i)
            EBR_SINGLE: begin
                a_wr_ok = 1'b1;
                a_rd_ok = 1'b1;
                b_wr_ok = 1'b0;
                b_rd_ok = 1'b0;
            end
            EBR_TRUE_DUAL: begin
                a_wr_ok = 1'b1;
                a_rd_ok = 1'b1;
                b_wr_ok = 1'b1;
                b_rd_ok = 1'b1;
            end
            EBR_PSEUDO_DUAL: begin
                a_wr_ok = 1'b1;
                a_rd_ok = 1'b0;
                b_wr_ok = 1'b0;
                b_rd_ok = 1'b1;
            end
            default: begin
                a_wr_ok = 1'b0;
                a_rd_ok = 1'b0;
                b_wr_ok = 1'b0;
                b_rd_ok = 1'b0;
            end
        endcase
    end

    // Port A input registers
    ebr_port_in u_a_in (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .clr_i   (sleep),
        .width_i (wa),
        .en_i    (a_en_i),
        .we_i    (a_we_i),
        .wr_ok_i (a_wr_ok),
        .rd_ok_i (a_rd_ok),
        .addr_i  (a_addr_i),
        .wdata_i (a_wdata_i),
        .wr_o    (a_wr),
        .rd_o    (a_rd),
        .addr_o  (a_addr),
        .wdata_o (a_wdata)
    );

    // Port B input registers
    ebr_port_in u_b_in (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .clr_i   (sleep),
        .width_i (wb),
        .en_i    (b_en_i),
        .we_i    (b_we_i),
        .wr_ok_i (b_wr_ok),
        .rd_ok_i (b_rd_ok),
        .addr_i  (b_addr_i),
        .wdata_i (b_wdata_i),
        .wr_o    (b_wr),
        .rd_o    (b_rd),
        .addr_o  (b_addr),
        .wdata_o (b_wdata)
    );

    // Array read, old contents seen when a write hits the same edge
    always_comb begin
        a_arr = read_word(mem_q, a_addr, wa);
        b_arr = read_word(mem_q, b_addr, wb);
    end

    // Array update: sleep loses contents, preload, then A, then B
    always_ff @(posedge mclk_i) begin
        logic [BIT_IDX_W-1:0] base;
        logic [BIT_IDX_W+7:0] ibase;
        int                   n;
        if (sleep) begin
            mem_q <= '0;
        end else if (init_we_i) begin
            ibase = (BIT_IDX_W+8)'(init_addr_i) * (BIT_IDX_W+8)'(DATA_W);
            for (int i = 0; i < DATA_W; i++) begin
                mem_q[int'(ibase) + i] <= init_data_i[i];
            end
        end else begin
            if (a_wr) begin
                base = bit_base(a_addr, wa);
                n    = width_bits(wa);
                for (int i = 0; i < DATA_W; i++) begin
                    if (i < n && (int'(base) + i) < ARRAY_BITS) begin
                        mem_q[int'(base) + i] <= a_wdata[i];
                    end
                end
            end
            // Colliding bits end up with port B data, undefined to users
            if (b_wr) begin
                base = bit_base(b_addr, wb);
                n    = width_bits(wb);
                for (int i = 0; i < DATA_W; i++) begin
                    if (i < n && (int'(base) + i) < ARRAY_BITS) begin
                        mem_q[int'(base) + i] <= b_wdata[i];
                    end
                end
            end
        end
    end

    // Port A read data path
    ebr_port_out u_a_out (
        .mclk_i     (mclk_i),
        .nrst_i     (nrst_i),
        .clr_i      (sleep),
        .out_reg_i  (out_reg_a_i),
        .rd_i       (a_rd),
        .arr_data_i (a_arr),
        .rdata_o    (a_rdata_o)
    );

    // Port B read data path
    ebr_port_out u_b_out (
        .mclk_i     (mclk_i),
        .nrst_i     (nrst_i),
        .clr_i      (sleep),
        .out_reg_i  (out_reg_b_i),
        .rd_i       (b_rd),
        .arr_data_i (b_arr),
        .rdata_o    (b_rdata_o)
    );

    // Flags a true dual port request for the missing x36 shape
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            shape_err_o <= 1'b0;
        end else begin
            shape_err_o <= (mode_i == EBR_TRUE_DUAL) &&
                           (width_a_i == EBR_X36 ||
                            width_b_i == EBR_X36);
        end
    end

endmodule

// ### ebr_pkg.sv
// Shared constants, types and shape helpers for the embedded block RAM.
// Assumes a single clock domain; all users import ebr_pkg::*.
package ebr_pkg;

    // Array size and port widths
    localparam int ARRAY_BITS  = 9216;
    localparam int DATA_W      = 36;
    localparam int ADDR_W      = 13;
    localparam int BIT_IDX_W   = 14;
    localparam int INIT_ADDR_W = 8;

    // Values after reset
    localparam logic [DATA_W-1:0] RST_DATA = 36'h0_0000_0000;
    localparam logic [ADDR_W-1:0] RST_ADDR = 13'h0000;

    // Word depth for each shape
    localparam int DEPTH_X1  = 8192;
    localparam int DEPTH_X2  = 4096;
    localparam int DEPTH_X4  = 2048;
    localparam int DEPTH_X9  = 1024;
    localparam int DEPTH_X18 = 512;
    localparam int DEPTH_X36 = 256;

    // Port arrangement
    typedef enum logic [1:0] {
        EBR_SINGLE,
        EBR_TRUE_DUAL,
        EBR_PSEUDO_DUAL
    } ebr_mode_type;

    // Port data width
    typedef enum logic [2:0] {
        EBR_X1,
        EBR_X2,
        EBR_X4,
        EBR_X9,
        EBR_X18,
        EBR_X36
    } ebr_width_type;

    // Bits per word of a shape
    function automatic int width_bits(input ebr_width_type w);
        case (w)
            EBR_X1:  width_bits = 1;
            EBR_X2:  width_bits = 2;
            EBR_X4:  width_bits = 4;
            EBR_X9:  width_bits = 9;
            EBR_X18: width_bits = 18;
            EBR_X36: width_bits = 36;
            default: width_bits = 1;
        endcase
    endfunction

    // Words per port of a shape
    function automatic int word_depth(input ebr_width_type w);
        case (w)
            EBR_X1:  word_depth = DEPTH_X1;
            EBR_X2:  word_depth = DEPTH_X2;
            EBR_X4:  word_depth = DEPTH_X4;
            EBR_X9:  word_depth = DEPTH_X9;
            EBR_X18: word_depth = DEPTH_X18;
            EBR_X36: word_depth = DEPTH_X36;
            default: word_depth = DEPTH_X1;
        endcase
    endfunction

    // Width actually used: true dual port has no x36 shape
    function automatic ebr_width_type eff_width(input ebr_mode_type m,
                                                input ebr_width_type w);
        if (m == EBR_TRUE_DUAL && w == EBR_X36) begin
            eff_width = EBR_X18;
        end else begin
            eff_width = w;
        end
    endfunction

endpackage

// ### ebr_port_in.sv
// Input register stage of one memory port.
// Assumes synchronous inputs on mclk_i; width is stable during use.
`timescale 1ns/1ps
module ebr_port_in (
    input  wire logic                  mclk_i,
    input  wire logic                  nrst_i,
    input  wire logic                  clr_i,
    input  ebr_pkg::ebr_width_type     width_i,
    input  wire logic                  en_i,
    input  wire logic                  we_i,
    input  wire logic                  wr_ok_i,
    input  wire logic                  rd_ok_i,
    input  wire logic [ebr_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [ebr_pkg::DATA_W-1:0] wdata_i,
    output logic                       wr_o,
    output logic                       rd_o,
    output logic [ebr_pkg::ADDR_W-1:0] addr_o,
    output logic [ebr_pkg::DATA_W-1:0] wdata_o
);
    import ebr_pkg::*;

    logic [ADDR_W-1:0] addr_mask;
    logic [DATA_W-1:0] data_mask;

    // Address bits past the depth and data bits past the width drop out
    always_comb begin
        addr_mask = ADDR_W'(word_depth(width_i) - 1);
        data_mask = ~(RST_DATA) >> (DATA_W - width_bits(width_i));
    end

    // Address, data and strobes registered at the array input
    always_ff @(posedge mclk_i) begin
        if (!nrst_i || clr_i) begin
            wr_o    <= 1'b0;
            rd_o    <= 1'b0;
            addr_o  <= RST_ADDR;
            wdata_o <= RST_DATA;
        end else begin
            wr_o    <= en_i & we_i & wr_ok_i;
            rd_o    <= en_i & ~we_i & rd_ok_i;
            addr_o  <= addr_i & addr_mask;
            wdata_o <= wdata_i & data_mask;
        end
    end

endmodule

// ### ebr_port_out.sv
// Read data path of one port with optional output register.
// Assumes array data is already aligned and masked to the port width.
`timescale 1ns/1ps
module ebr_port_out (
    input  wire logic                       mclk_i,
    input  wire logic                       nrst_i,
    input  wire logic                       clr_i,
    input  wire logic                       out_reg_i,
    input  wire logic                       rd_i,
    input  wire logic [ebr_pkg::DATA_W-1:0] arr_data_i,
    output logic      [ebr_pkg::DATA_W-1:0] rdata_o
);
    import ebr_pkg::*;

    logic              stage_vld_q;
    logic [DATA_W-1:0] stage_q;

    // Array output stage, one clock after the address register
    always_ff @(posedge mclk_i) begin
        if (!nrst_i || clr_i) begin
            stage_vld_q <= 1'b0;
            stage_q     <= RST_DATA;
        end else begin
            stage_vld_q <= rd_i;
            if (rd_i) begin
                stage_q <= arr_data_i;
            end
        end
    end

    // Port output: straight array data or one more register stage
    always_ff @(posedge mclk_i) begin
        if (!nrst_i || clr_i) begin
            rdata_o <= RST_DATA;
        end else if (out_reg_i) begin
            if (stage_vld_q) begin
                rdata_o <= stage_q;
            end
        end else if (rd_i) begin
            rdata_o <= arr_data_i;
        end
    end

endmodule

// ### ebr_block_ram_monitor.sv
// Checker for the block RAM top: clearing, latency and mode relations.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
module ebr_block_ram_mon (
    input  wire logic                       mclk_i,
    input  wire logic                       nrst_i,
    input  wire logic                       low_power_request_n_i,
    input  ebr_pkg::ebr_mode_type           mode_i,
    input  ebr_pkg::ebr_width_type          width_a_i,
    input  ebr_pkg::ebr_width_type          width_b_i,
    input  wire logic                       out_reg_a_i,
    input  wire logic                       a_en_i,
    input  wire logic                       a_we_i,
    input  wire logic                       b_en_i,
    input  wire logic                       b_we_i,
    input  wire logic [ebr_pkg::DATA_W-1:0] a_rdata_o,
    input  wire logic [ebr_pkg::DATA_W-1:0] b_rdata_o,
    input  wire logic                       shape_err_o
);
    import ebr_pkg::*;
    logic rd_a;
    logic rd_b;

    // Read requests per port
    assign rd_a = a_en_i & ~a_we_i;
    assign rd_b = b_en_i & ~b_we_i;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    a_reset_zero: assert property (
        $rose(nrst_i) |-> a_rdata_o == '0 && b_rdata_o == '0)
        else $error("read data not zero after reset");
    a_sleep_clear: assert property (
        !low_power_request_n_i |=> a_rdata_o == '0 && b_rdata_o == '0)
        else $error("read data not cleared in sleep");
    a_shape_flag: assert property (
        low_power_request_n_i |=> shape_err_o == $past(mode_i ==
        EBR_TRUE_DUAL && (width_a_i == EBR_X36 || width_b_i == EBR_X36)))
        else $error("shape error flag wrong");
    a_a_read_cause: assert property (
        $changed(a_rdata_o) && $past(nrst_i) && $past(low_power_request_n_i)
        |-> $past(rd_a, 2) || $past(rd_a, 3))
        else $error("port a data changed without a read");
    a_b_read_cause: assert property (
        $changed(b_rdata_o) && $past(nrst_i) && $past(low_power_request_n_i)
        |-> $past(rd_b, 2) || $past(rd_b, 3))
        else $error("port b data changed without a read");
    a_pseudo_a_noread: assert property (
        $past(mode_i, 2) == EBR_PSEUDO_DUAL && $past(mode_i, 3) ==
        EBR_PSEUDO_DUAL && $past(nrst_i) && $past(low_power_request_n_i)
        |-> $stable(a_rdata_o))
        else $error("port a answered a read in pseudo mode");
    a_single_b_idle: assert property (
        $past(mode_i, 2) == EBR_SINGLE && $past(mode_i, 3) == EBR_SINGLE
        && $past(nrst_i) && $past(low_power_request_n_i)
        |-> $stable(b_rdata_o))
        else $error("port b answered in single mode");
    a_outreg_wait: assert property (
        (!rd_a && out_reg_a_i) ##1 (rd_a && out_reg_a_i) ##1
        (out_reg_a_i && low_power_request_n_i) |=> $stable(a_rdata_o))
        else $error("registered read came one clock early");
    a_width_mask: assert property (
        $changed(b_rdata_o) && width_b_i == EBR_X9 && $past(width_b_i, 2)
        == EBR_X9 && $past(width_b_i, 3) == EBR_X9
        |-> b_rdata_o[DATA_W-1:9] == '0)
        else $error("port b bits above width not zero");

    c_reg_read: cover property (rd_a && out_reg_a_i);
    c_shape: cover property ($rose(shape_err_o));
    c_sleep: cover property ($fell(low_power_request_n_i));
endmodule

bind ebr_block_ram ebr_block_ram_mon u_mon (
    .mclk_i(mclk_i), .nrst_i(nrst_i),
    .low_power_request_n_i(low_power_request_n_i), .mode_i(mode_i),
    .width_a_i(width_a_i), .width_b_i(width_b_i),
    .out_reg_a_i(out_reg_a_i), .a_en_i(a_en_i), .a_we_i(a_we_i),
    .b_en_i(b_en_i), .b_we_i(b_we_i), .a_rdata_o(a_rdata_o),
    .b_rdata_o(b_rdata_o), .shape_err_o(shape_err_o));

// ### ebr_user_port.sv
// User logic model on one memory port: one access per call.
// Assumes calls start just after a rising edge of mclk_i.
`timescale 1ns/1ps
module ebr_user_port (
    input  wire logic                       mclk_i,
    output logic                            en_o,
    output logic                            we_o,
    output logic [ebr_pkg::ADDR_W-1:0]      addr_o,
    output logic [ebr_pkg::DATA_W-1:0]      wdata_o
);
    import ebr_pkg::*;

    // Idle port at time zero, writes held off
    initial begin
        en_o = 1'b0;
        we_o = 1'b0;
        addr_o = '0;
        wdata_o = '0;
    end

    // Caller keeps both ports off the same bits in one cycle
    task automatic access(input logic w, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d);
        en_o <= 1'b1;
        we_o <= w;
        addr_o <= a;
        wdata_o <= d;
        @(posedge mclk_i);
        en_o <= 1'b0;
        we_o <= ~w;
        addr_o <= ~a; // Released lines do not keep the old value
        wdata_o <= ~d;
    endtask
endmodule

// ### tb.sv
// Testbench for the block RAM: preload, shapes, latency, modes, sleep.
// Assumes the port models of ebr_user_port.sv and the shared package.
`timescale 1ns/1ps
module tb;
    import ebr_pkg::*;
    logic                  clk = 1'b0;
    logic                  nrst, lpn, ora, orb, iwe, serr;
    ebr_mode_type          mode;
    ebr_width_type         wa, wb;
    logic [7:0]            iaddr;
    logic [35:0]           idata, a_rd, b_rd, a_wd, b_wd;
    logic                  a_en, a_we, b_en, b_we;
    logic [12:0]           a_addr, b_addr;
    logic [ARRAY_BITS-1:0] ref_mem;
    int                    fails = 0;
    int                    samples_checked = 0;
    int                    wbits[6] = '{1, 2, 4, 9, 18, 36};

    always #2 clk = ~clk;

    ebr_block_ram dut (
        .mclk_i(clk), .nrst_i(nrst), .low_power_request_n_i(lpn),
        .mode_i(mode), .width_a_i(wa), .width_b_i(wb),
        .out_reg_a_i(ora), .out_reg_b_i(orb), .init_we_i(iwe),
        .init_addr_i(iaddr), .init_data_i(idata), .a_en_i(a_en),
        .a_we_i(a_we), .a_addr_i(a_addr), .a_wdata_i(a_wd),
        .b_en_i(b_en), .b_we_i(b_we), .b_addr_i(b_addr),
        .b_wdata_i(b_wd), .a_rdata_o(a_rd), .b_rdata_o(b_rd),
        .shape_err_o(serr));
    ebr_user_port ua (.mclk_i(clk), .en_o(a_en), .we_o(a_we),
        .addr_o(a_addr), .wdata_o(a_wd));
    ebr_user_port ub (.mclk_i(clk), .en_o(b_en), .we_o(b_we),
        .addr_o(b_addr), .wdata_o(b_wd));

    // Compare and count
    task automatic chk(string nm, logic [35:0] e, logic [35:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Word k of width n is bits k*n up, LSB first
    function automatic logic [35:0] exp_word(int a, ebr_width_type w);
        int n;
        n = wbits[int'(w)];
        exp_word = '0;
        for (int i = 0; i < n; i++) exp_word[i] = ref_mem[a*n+i];
    endfunction

    task automatic wr(bit b, int a, ebr_width_type w, logic [35:0] d);
        int n;
        n = wbits[int'(w)];
        for (int i = 0; i < n; i++) ref_mem[a*n+i] = d[i];
        if (b) ub.access(1'b1, ADDR_W'(a), d);
        else ua.access(1'b1, ADDR_W'(a), d);
        // Idle edge so the next request never reassigns in this step
        @(posedge clk);
    endtask

    // Read, wait the latency, compare
    task automatic rd(bit b, int a, int lat, ebr_width_type w);
        if (b) ub.access(1'b0, ADDR_W'(a), '0);
        else ua.access(1'b0, ADDR_W'(a), '0);
        repeat (lat) @(posedge clk);
        #1;
        chk(b ? "b_rdata" : "a_rdata", exp_word(a, w), b ? b_rd : a_rd);
    endtask

    task automatic t_rom();
        logic [35:0] d;
        for (int j = 0; j < 8; j++) begin
            @(posedge clk);
            d = 36'h9A5C31E7F ^ (36'h012345679 * 36'(j));
            iwe <= 1'b1;
            iaddr <= 8'(j);
            idata <= d;
            ref_mem[j*36 +: 36] = d;
        end
        @(posedge clk);
        iwe <= 1'b0;
        ub.access(1'b0, 13'h0001, '0);
        repeat (2) @(posedge clk);
        #1;
        chk("b_rdata single", '0, b_rd);
        for (int w = 0; w < 6; w++) begin
            wa <= ebr_width_type'(w);
            for (int k = 1; k < 8; k += 2) begin
                rd(1'b0, k, 1, ebr_width_type'(w));
            end
        end
    endtask

    task automatic t_lat();
        logic [35:0] prev;
        wa <= EBR_X36;
        ora <= 1'b1;
        prev = a_rd;
        ua.access(1'b0, 13'h0002, '0);
        @(posedge clk);
        #1;
        chk("a_rdata early", prev, a_rd);
        @(posedge clk);
        #1;
        chk("a_rdata late", exp_word(2, EBR_X36), a_rd);
        wr(1'b0, 3, EBR_X36, 36'hF0F0F0F0F);
        rd(1'b0, 3, 2, EBR_X36);
        ora <= 1'b0;
    endtask

    task automatic t_dual();
        mode <= EBR_TRUE_DUAL;
        wa <= EBR_X4;
        wb <= EBR_X9;
        wr(1'b0, 20, EBR_X4, 36'h00000000D);
        rd(1'b1, 9, 1, EBR_X9);
        wr(1'b1, 2, EBR_X9, 36'h0000001A5);
        rd(1'b0, 5, 1, EBR_X4);
        wa <= EBR_X36;
        repeat (2) @(posedge clk);
        #1;
        chk("shape_err", 36'h000000001, 36'(serr));
    endtask

    task automatic t_pseudo();
        logic [35:0] prev;
        mode <= EBR_PSEUDO_DUAL;
        wa <= EBR_X18;
        wb <= EBR_X36;
        wr(1'b0, 4, EBR_X18, 36'h00002C5A7);
        rd(1'b1, 2, 1, EBR_X36);
        prev = a_rd;
        ua.access(1'b0, 13'h0000, '0);
        repeat (2) @(posedge clk);
        #1;
        chk("a_rdata pseudo", prev, a_rd);
        ub.access(1'b1, 13'h0002, 36'h123456789);
        @(posedge clk);
        rd(1'b1, 2, 1, EBR_X36);
        // Port B through its output register, two clocks of latency
        orb <= 1'b1;
        rd(1'b1, 3, 2, EBR_X36);
        orb <= 1'b0;
    endtask

    task automatic t_sleep();
        mode <= EBR_SINGLE;
        wa <= EBR_X36;
        wr(1'b0, 5, EBR_X36, 36'hABCDE1234);
        rd(1'b0, 5, 1, EBR_X36);
        lpn <= 1'b0;
        repeat (3) @(posedge clk);
        lpn <= 1'b1;
        #1;
        chk("a_rdata sleep", '0, a_rd);
        ref_mem = '0;
        rd(1'b0, 1, 1, EBR_X36);
    endtask

    task automatic finish_test();
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        nrst = 1'b0;
        lpn = 1'b1;
        mode = EBR_SINGLE;
        wa = EBR_X36;
        wb = EBR_X36;
        ora = 1'b0;
        orb = 1'b0;
        iwe = 1'b0;
        iaddr = '0;
        idata = '0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        t_rom();
        t_lat();
        t_dual();
        t_pseudo();
        t_sleep();
        finish_test();
    end

    // Watchdog, far beyond the hundred or so cycles needed
    initial begin
        #8000;
        fails++;
        $display("[ERR] watchdog expected done seen timeout");
        finish_test();
    end
endmodule
